// file: hw/fgti_pkg.sv
// Package: constants and types for the translation invalidate unit
`default_nettype none

package fgti_pkg;
  // Field widths of cached translations and register address width
  localparam int ADDRESS_SPACE_IDENTIFIER_W = 16;
  localparam int VIRTUAL_MACHINE_IDENTIFIER_W = 14;
  localparam int VPN_W  = 27;
  localparam int PPN_W  = 44;
  localparam int ADDR_W = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 4'h8;

  // Control register bit positions and reset value
  localparam int CTRL_TVM    = 0;
  localparam int CTRL_TRAP_GUEST_VIRTUAL_MEMORY   = 1;
  localparam int CTRL_MADUE  = 2;
  localparam int CTRL_HADUE  = 3;
  localparam int CTRL_SIMPLE = 4;
  localparam int CTRL_W      = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_SUP_INV     = 3'h0,
    OP_GUEST_INV   = 3'h1,
    OP_GSTAGE_INV  = 3'h2,
    OP_SUP_FULL    = 3'h3,
    OP_GUEST_FULL  = 3'h4,
    OP_GSTAGE_FULL = 3'h5,
    OP_STORE_FENCE = 3'h6,
    OP_WALK_FENCE  = 3'h7
  } fgti_op_type;

  typedef enum logic [1:0] {
    PRIV_USER = 2'h0,
    PRIV_SUP  = 2'h1,
    PRIV_MACH = 2'h3
  } fgti_priv_type;

  typedef enum logic [1:0] {
    EXC_NONE    = 2'h0,
    EXC_ILLEGAL = 2'h1,
    EXC_VIRTUAL = 2'h2
  } fgti_exc_type;

  typedef enum logic [1:0] {
    STG_SUP    = 2'h0,
    STG_GUEST  = 2'h1,
    STG_GSTAGE = 2'h2
  } fgti_stage_type;

  // Sequencer states, Gray coded along idle-wait-apply-done
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_WAIT  = 2'h1,
    ST_APPLY = 2'h3,
    ST_DONE  = 2'h2
  } fgti_state_type;

  typedef struct packed {
    fgti_op_type         kind;
    fgti_priv_type       priv;
    logic                virt;
    logic                rs1_zero;
    logic                rs2_zero;
    logic [VPN_W-1:0]    vpn;
    logic [ADDRESS_SPACE_IDENTIFIER_W-1:0]   id;
    logic [VIRTUAL_MACHINE_IDENTIFIER_W-1:0]   virtual_machine_identifier;
  } fgti_req_type;

  typedef struct packed {
    logic                valid;
    fgti_stage_type      stage;
    logic                global;
    logic [ADDRESS_SPACE_IDENTIFIER_W-1:0]   address_space_identifier;
    logic [VIRTUAL_MACHINE_IDENTIFIER_W-1:0]   virtual_machine_identifier;
    logic [VPN_W-1:0]    vpn;
    logic [PPN_W-1:0]    ppn;
  } fgti_entry_type;

  typedef struct packed {
    fgti_stage_type      stage;
    logic                rs1_zero;
    logic                rs2_zero;
    logic [VPN_W-1:0]    vpn;
    logic [ADDRESS_SPACE_IDENTIFIER_W-1:0]   id;
    logic [VIRTUAL_MACHINE_IDENTIFIER_W-1:0]   virtual_machine_identifier;
  } fgti_cmd_type;

  typedef struct packed {
    logic                valid;
    fgti_exc_type        exc;
  } fgti_done_type;
endpackage

`default_nettype wire

// file: hw/fgti_trap_check.sv
// Privilege and trap-control check for maintenance operations
`timescale 1ns/1ps
`default_nettype none

module fgti_trap_check
  import fgti_pkg::*;
#(
  parameter bit HYP_PRESENT = 1'b1
) (
  // Operation and privilege context
  input  wire fgti_op_type   kind,
  input  wire fgti_priv_type priv,
  input  wire logic          virt,
  // Trap controls
  input  wire logic          trap_virtual_memory,
  input  wire logic          trap_guest_virtual_memory,
  // Verdict
  output fgti_exc_type       exc
);
  logic is_guest;
  logic is_gstage;
  logic is_sup;

  // Ordering fences fall through every trap-bit test
  always_comb begin
    is_guest  = kind inside {OP_GUEST_INV, OP_GUEST_FULL};
    is_gstage = kind inside {OP_GSTAGE_INV, OP_GSTAGE_FULL};
    is_sup    = kind inside {OP_SUP_INV, OP_SUP_FULL};
    exc       = EXC_NONE;
    if ((is_guest || is_gstage) && !HYP_PRESENT) begin
      exc = EXC_ILLEGAL;
    end else if (priv == PRIV_USER) begin
      exc = virt ? EXC_VIRTUAL : EXC_ILLEGAL;
    end else if (virt) begin
      if (is_guest || is_gstage) begin
        exc = EXC_VIRTUAL;
      end else if (is_sup && trap_guest_virtual_memory) begin
        exc = EXC_VIRTUAL;
      end
    end else if (priv == PRIV_SUP && trap_virtual_memory && (is_sup || is_gstage)) begin
      exc = EXC_ILLEGAL;
    end
  end
endmodule // fgti_trap_check

`default_nettype wire

// file: hw/fgti_unit.sv
// Translation cache maintenance unit with register slave
`timescale 1ns/1ps
`default_nettype none

module fgti_unit
  import fgti_pkg::*;
#(
  parameter int ENTRIES     = 8,
  parameter bit HYP_PRESENT = 1'b1,
  parameter bit AD_SUPPORT  = 1'b1
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // AXI4-Lite register slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Operations from the pipeline
  input  wire logic              op_valid,
  output logic                   op_ready,
  input  wire fgti_req_type      op_req,
  output fgti_done_type          op_done,
  // Store buffer state
  input  wire logic              stores_drained,
  // Page-table walker
  input  wire logic              walk_req,
  output logic                   walk_grant,
  input  wire logic              fill_valid,
  input  wire fgti_entry_type    fill_entry,
  input  wire logic              lookup_valid,
  input  wire fgti_entry_type    lookup_key,
  output logic                   lookup_hit,
  output logic [PPN_W-1:0]       lookup_ppn,
  // Access and dirty bit requests
  input  wire logic              ad_req,
  input  wire logic              ad_vs_stage,
  output logic                   ad_update,
  output logic                   ad_fault
);
  localparam int IDX_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(ENTRIES - 1);
  // Enables exist only where the feature exists
  localparam logic [CTRL_W-1:0] CTRL_MASK = {1'b1,
    AD_SUPPORT && HYP_PRESENT, AD_SUPPORT, HYP_PRESENT, 1'b1};

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Register offsets that answer OKAY
  function automatic logic is_mapped(logic [ADDR_W-1:0] a);
    return a == OFS_CTRL || a == OFS_STATUS || a == OFS_COUNT;
  endfunction

  function automatic logic is_inval(fgti_op_type k);
    return k inside {OP_SUP_INV, OP_GUEST_INV, OP_GSTAGE_INV};
  endfunction

  function automatic logic is_full(fgti_op_type k);
    return k inside {OP_SUP_FULL, OP_GUEST_FULL, OP_GSTAGE_FULL};
  endfunction

  // Same target selection for an invalidate and its full fence
  function automatic fgti_cmd_type to_cmd(fgti_req_type r);
    fgti_cmd_type c;
    c.rs1_zero = r.rs1_zero;
    c.rs2_zero = r.rs2_zero;
    c.vpn      = r.vpn;
    c.id       = r.id;
    c.virtual_machine_identifier     = r.virtual_machine_identifier;
    case (r.kind)
      OP_GUEST_INV, OP_GUEST_FULL: begin
        c.stage = STG_GUEST;
      end
      OP_GSTAGE_INV, OP_GSTAGE_FULL: begin
        c.stage = STG_GSTAGE;
      end
      default: begin
        c.stage = r.virt ? STG_GUEST : STG_SUP;
      end
    endcase
    return c;
  endfunction

  // Entry selected by an invalidate or full fence
  function automatic logic inv_match(fgti_entry_type e,
                                     fgti_cmd_type c);
    logic addr_ok;
    logic id_ok;
    addr_ok = c.rs1_zero || e.vpn == c.vpn;
    if (c.stage == STG_GSTAGE) begin
      id_ok = c.rs2_zero || e.virtual_machine_identifier == c.id[VIRTUAL_MACHINE_IDENTIFIER_W-1:0];
    end else begin
      id_ok = c.rs2_zero || (!e.global && e.address_space_identifier == c.id);
      if (c.stage == STG_GUEST) begin
        id_ok = id_ok && e.virtual_machine_identifier == c.virtual_machine_identifier;
      end
    end
    return e.valid && e.stage == c.stage && addr_ok && id_ok;
  endfunction

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------

  logic [CTRL_W-1:0]  ctrl;
  logic [31:0]        inval_count;
  fgti_state_type     state;
  fgti_state_type     next_state;
  fgti_req_type       cur_req;
  fgti_exc_type       cur_exc;
  logic               pend_valid;
  fgti_cmd_type       pend_cmd;
  fgti_entry_type     tlb [ENTRIES];
  logic [IDX_W-1:0]   victim;
  logic [7:0]         valid_num;
  fgti_exc_type       exc;
  logic               accept;
  logic               needs_stores;
  logic               apply_now;
  fgti_cmd_type       apply_cmd;
  logic               fill_we;
  logic               aw_held;
  logic               w_held;
  logic [ADDR_W-1:0]  aw_addr;
  logic [31:0]        w_data;
  logic               w_strb0;

  // ---------------------------------------------------------------
  // Register slave
  // ---------------------------------------------------------------

  // Address and data are held apart so either may come first
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      w_held  <= 1'b0;
      w_data  <= '0;
      w_strb0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      w_data  <= s_axi_wdata;
      w_strb0 <= s_axi_wstrb[0];
    end else if (aw_held && w_held) begin
      w_held <= 1'b0;
    end
  end

  // Write response once both halves are in
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (aw_held && w_held) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register; only byte lane 0 carries live bits
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl <= CTRL_RESET;
    end else if (aw_held && w_held && aw_addr == OFS_CTRL && w_strb0) begin
      ctrl <= w_data[CTRL_W-1:0] & CTRL_MASK;
    end
  end

  // Read data; unmapped words read zero with an error
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_CTRL:   s_axi_rdata <= {27'h0, ctrl};
        OFS_STATUS: s_axi_rdata <= {16'h0, valid_num, 4'h0,
                                    stores_drained, pend_valid,
                                    state};
        OFS_COUNT:  s_axi_rdata <= inval_count;
        default:    s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Operation sequencer
  // ---------------------------------------------------------------

  fgti_trap_check #(
    .HYP_PRESENT (HYP_PRESENT)
  ) u_trap_check (
    .kind (op_req.kind),
    .priv (op_req.priv),
    .virt (op_req.virt),
    .trap_virtual_memory  (ctrl[CTRL_TVM]),
    .trap_guest_virtual_memory (ctrl[CTRL_TRAP_GUEST_VIRTUAL_MEMORY]),
    .exc  (exc)
  );

  assign op_ready = state == ST_IDLE;
  assign accept   = op_valid && op_ready;

  // Which operations must wait for the store buffer
  always_comb begin
    needs_stores = 1'b0;
    if (is_full(op_req.kind)) begin
      needs_stores = 1'b1;
    end else if (is_inval(op_req.kind)) begin
      needs_stores = ctrl[CTRL_SIMPLE];
    end else if (op_req.kind == OP_STORE_FENCE) begin
      needs_stores = !ctrl[CTRL_SIMPLE];
    end
  end

  // Next state; walk fence needs no wait since queue drains first
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          if (exc == EXC_NONE && needs_stores) begin
            next_state = ST_WAIT;
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_WAIT: begin
        if (stores_drained) begin
          if (is_full(cur_req.kind) || is_inval(cur_req.kind)) begin
            next_state = ST_APPLY;
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_APPLY: next_state = ST_DONE;
      ST_DONE:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture of the accepted operation and its verdict
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cur_req <= '0;
      cur_exc <= EXC_NONE;
    end else if (accept) begin
      cur_req <= op_req;
      cur_exc <= exc;
    end
  end

  assign op_done.valid = state == ST_DONE;
  assign op_done.exc   = cur_exc;

  // Pipelined invalidate: retire at once, apply next cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pend_valid <= 1'b0;
      pend_cmd   <= '0;
    end else if (accept && exc == EXC_NONE && is_inval(op_req.kind)
                 && !ctrl[CTRL_SIMPLE]) begin
      pend_valid <= 1'b1;
      pend_cmd   <= to_cmd(op_req);
    end else begin
      pend_valid <= 1'b0;
    end
  end

  // Queued invalidate and fence apply never share a cycle
  assign apply_now = pend_valid || state == ST_APPLY;
  assign apply_cmd = pend_valid ? pend_cmd : to_cmd(cur_req);

  // Walks wait only in the cycle an invalidate or full fence is applied
  assign walk_grant = walk_req && !apply_now;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      inval_count <= '0;
    end else if (apply_now) begin
      inval_count <= inval_count + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // Translation cache
  // ---------------------------------------------------------------

  // Invalid entries are never stored; stale fills during apply drop
  assign fill_we = fill_valid && fill_entry.valid && !apply_now;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      victim <= '0;
    end else if (fill_we) begin
      victim <= (victim == LAST_IDX) ? '0 : victim + IDX_W'(1);
    end
  end

  for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
    // Invalidate wins over a fill of the same slot
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        tlb[i] <= '0;
      end else if (apply_now && inv_match(tlb[i], apply_cmd)) begin
        tlb[i].valid <= 1'b0;
      end else if (fill_we && victim == IDX_W'(i)) begin
        tlb[i] <= fill_entry;
      end
    end
  end

  // Occupancy for status
  always_comb begin
    valid_num = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      valid_num = valid_num + {7'h0, tlb[i].valid};
    end
  end

  // Lookup answers one cycle after the request
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      lookup_hit <= 1'b0;
      lookup_ppn <= '0;
    end else begin
      lookup_hit <= 1'b0;
      for (int i = 0; i < ENTRIES; i++) begin
        if (lookup_valid && tlb[i].valid
            && tlb[i].stage == lookup_key.stage
            && tlb[i].vpn == lookup_key.vpn
            && (lookup_key.stage == STG_SUP
                || tlb[i].virtual_machine_identifier == lookup_key.virtual_machine_identifier)
            && (lookup_key.stage == STG_GSTAGE || tlb[i].global
                || tlb[i].address_space_identifier == lookup_key.address_space_identifier)) begin
          lookup_hit <= 1'b1;
          lookup_ppn <= tlb[i].ppn;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Access and dirty bit updates
  // ---------------------------------------------------------------

  // Guest first stage obeys the hypervisor enable, others machine
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ad_update <= 1'b0;
      ad_fault  <= 1'b0;
    end else begin
      ad_update <= ad_req && (ad_vs_stage ? ctrl[CTRL_HADUE]
                                          : ctrl[CTRL_MADUE]);
      ad_fault  <= ad_req && !(ad_vs_stage ? ctrl[CTRL_HADUE]
                                           : ctrl[CTRL_MADUE]);
    end
  end
endmodule // fgti_unit

`default_nettype wire

// file: test/fgti_store_model.sv
// Store buffer model: tells when earlier stores are visible
`timescale 1ns/1ps
`default_nettype none
module fgti_store_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // New store and drain speed
  input  wire logic push,
  input  wire logic slow,
  // All earlier stores visible
  output logic      drained
);
  logic [3:0] cnt;
  // Slow drain makes a waiting fence really wait
  always_ff @(posedge clock) begin
    if (!reset_n) cnt <= 4'h0;
    else if (push) cnt <= slow ? 4'h8 : 4'h1;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  assign drained = (cnt == 4'h0);
endmodule // fgti_store_model
`default_nettype wire

// file: test/fgti_unit_assertions.sv
// Checker of operation, walker and A/D timing
`timescale 1ns/1ps
`default_nettype none
module fgti_unit_chk
  import fgti_pkg::*;
(
  // Clock and reset
  input wire logic          clock,
  input wire logic          reset_n,
  // Operations
  input wire logic          op_valid,
  input wire logic          op_ready,
  input wire fgti_req_type  op_req,
  input wire fgti_done_type op_done,
  // Walker and A/D
  input wire logic          walk_req,
  input wire logic          walk_grant,
  input wire logic          lookup_valid,
  input wire logic          lookup_hit,
  input wire logic          ad_req,
  input wire logic          ad_update,
  input wire logic          ad_fault
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Decode of the operation being taken
  wire take = op_valid && op_ready;
  wire fen  = op_req.kind inside {OP_STORE_FENCE, OP_WALK_FENCE};
  wire usr  = op_req.priv == PRIV_USER;
  wire inv  = op_req.kind inside {OP_SUP_INV, OP_GUEST_INV, OP_GSTAGE_INV};

  property p_busy; take |=> !op_ready; endproperty
  a_busy:
    assert property (p_busy) else $error("ready right after take");
  property p_pulse; op_done.valid |=> !op_done.valid; endproperty
  a_pulse:
    assert property (p_pulse) else $error("done longer than a cycle");
  property p_bound; take |-> ##[1:60] op_done.valid; endproperty
  a_bound:
    assert property (p_bound) else $error("operation never done");
  property p_user;
    take && inv && usr && !op_req.virt |=>
      op_done.valid && op_done.exc == EXC_ILLEGAL;
  endproperty
  a_user:
    assert property (p_user) else $error("user invalidate not illegal");
  property p_fvu;
    take && fen && usr && op_req.virt |=>
      op_done.valid && op_done.exc == EXC_VIRTUAL;
  endproperty
  a_fvu:
    assert property (p_fvu) else $error("fence in virtual user");
  property p_fsup;
    take && fen && !usr |->
      ##[1:60] (op_done.valid && op_done.exc == EXC_NONE);
  endproperty
  a_fsup:
    assert property (p_fsup) else $error("fence trapped");
  property p_grant; walk_grant |-> walk_req; endproperty
  a_grant:
    assert property (p_grant) else $error("grant without request");
  property p_look; lookup_hit |-> $past(lookup_valid); endproperty
  a_look:
    assert property (p_look) else $error("hit without lookup");
  property p_ad; ad_req |=> ad_update != ad_fault; endproperty
  a_ad:
    assert property (p_ad) else $error("no single A/D answer");
  property p_adc; ad_update || ad_fault |-> $past(ad_req); endproperty
  a_adc:
    assert property (p_adc) else $error("A/D answer without request");
endmodule // fgti_unit_chk

bind fgti_unit fgti_unit_chk u_chk (.*);
`default_nettype wire

// file: test/fgti_unit_tb.sv
// Self-checking bench for the translation invalidate unit
`timescale 1ns/1ps
`default_nettype none
module fgti_unit_tb
  import fgti_pkg::*;
;
  // ------------------------------
  // Signals and instances
  // ------------------------------
  logic              clock, reset_n, s_axi_awvalid, s_axi_awready;
  logic              s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rv, q;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
  logic              op_valid, op_ready, stores_drained, push, slow;
  logic              walk_req, walk_grant, fill_valid, lookup_valid;
  logic              lookup_hit, ad_req, ad_vs_stage, ad_update, ad_fault;
  logic [PPN_W-1:0]  lookup_ppn;
  fgti_req_type      op_req;
  fgti_done_type     op_done;
  fgti_exc_type      ex;
  fgti_entry_type    fill_entry, lookup_key, ent [4];
  fgti_priv_type     pv [5] = '{PRIV_USER, PRIV_SUP, PRIV_MACH,
                                PRIV_USER, PRIV_SUP};
  int                error_cnt = 0, comparisons = 0, seed = 32'h4592;

  fgti_unit dut (.*);
  fgti_store_model sb (.clock, .reset_n, .push, .slow,
                       .drained(stores_drained));

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic chk(string n, logic [43:0] e, logic [43:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One edge of a bounded wait; a hang ends the run
  task automatic tick(inout int n);
    @(posedge clock);
    n++;
    if (n > 200) begin
      error_cnt++;
      end_sim;
    end
  endtask

  // Bus cycle; the extra edge keeps strobes from being set twice at once
  task automatic axi(bit wr, logic [3:0] a, logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (wr ? s_axi_bvalid !== 1'b1 : s_axi_rvalid !== 1'b1);
    rsp = wr ? s_axi_bresp : s_axi_rresp;
    q = s_axi_rdata;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic op(fgti_op_type k, fgti_priv_type p, logic v,
                    logic [VPN_W-1:0] a, logic [ADDRESS_SPACE_IDENTIFIER_W-1:0] id);
    int n;
    n = 0;
    op_req <= '{k, p, v, 1'b0, 1'b0, a, id, 14'h5};
    op_valid <= 1'b1;
    do tick(n); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    do tick(n); while (op_done.valid !== 1'b1);
    ex = op_done.exc;
  endtask

  task automatic fill(fgti_entry_type e);
    fill_entry <= e;
    fill_valid <= 1'b1;
    @(posedge clock);
    fill_valid <= 1'b0;
    @(posedge clock);
  endtask

  task automatic look(fgti_entry_type e, logic h);
    lookup_key <= e;
    lookup_valid <= 1'b1;
    @(posedge clock);
    lookup_valid <= 1'b0;
    @(posedge clock);
    chk("hit", h, lookup_hit);
    if (h) chk("ppn", e.ppn, lookup_ppn);
  endtask

  // Virtual checks come before the trap bits
  function automatic fgti_exc_type exp_exc(fgti_op_type k,
      fgti_priv_type p, logic v, logic trap_virtual_memory, logic trap_guest_virtual_memory);
    logic fen, usr, gst;
    fen = k inside {OP_STORE_FENCE, OP_WALK_FENCE};
    usr = p == PRIV_USER;
    gst = !fen && !(k inside {OP_SUP_INV, OP_SUP_FULL});
    if (usr && !v) return EXC_ILLEGAL;
    if (v && (usr || gst)) return EXC_VIRTUAL;
    if (fen) return EXC_NONE;
    if (v && trap_guest_virtual_memory) return EXC_VIRTUAL;
    // Machine trap bit only reaches non-virtual supervisor
    if (v || p != PRIV_SUP || !trap_virtual_memory) return EXC_NONE;
    if (k inside {OP_GUEST_INV, OP_GUEST_FULL}) return EXC_NONE;
    return EXC_ILLEGAL;
  endfunction

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    fgti_op_type kd;
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, op_valid, push, slow} = '0;
    {walk_req, fill_valid, lookup_valid, ad_req, ad_vs_stage} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {op_req, fill_entry, lookup_key} = '0;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    walk_req <= 1'b1;
    @(posedge clock);
    axi(0, OFS_CTRL, 0);
    chk("ctrl", CTRL_RESET, q);
    axi(1, OFS_CTRL, 32'h3f);
    chk("bresp", RESP_OKAY, rsp);
    axi(0, OFS_CTRL, 0);
    chk("ctrl", 32'h1f, q);
    axi(0, 4'hc, 0);
    chk("resp", RESP_SLVERR, rsp);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      axi(1, OFS_CTRL, c);
      for (int k = 0; k < 40; k++) begin
        kd = fgti_op_type'(k / 5);
        rv = $random(seed);
        op(kd, pv[k % 5], k % 5 > 2, rv[26:0], rv[31:16]);
        chk("exc", exp_exc(kd, pv[k % 5], k % 5 > 2, c[0], c[1]), ex);
      end
    end
    $display("test traps done");
    axi(1, OFS_CTRL, 0);
    rv = $random(seed);
    ent[0] = '{1'b1, STG_SUP, 1'b0, rv[15:0], 14'h5, rv[26:0], {12'h0, rv}};
    ent[1] = ent[0];
    ent[1].vpn = rv[26:0] + 27'h1;
    ent[2] = ent[0];
    ent[2].stage = STG_GSTAGE;
    ent[2].virtual_machine_identifier = 14'h9;
    ent[3] = ent[0];
    ent[3].valid = 1'b0;
    ent[3].vpn = rv[26:0] + 27'h2;
    for (int i = 0; i < 4; i++) fill(ent[i]);
    for (int i = 0; i < 4; i++) look(ent[i], i < 3);
    push <= 1'b1;
    @(posedge clock);
    push <= 1'b0;
    op(OP_STORE_FENCE, PRIV_SUP, 1'b0, 27'h0, 16'h0);
    op(OP_SUP_INV, PRIV_SUP, 1'b0, rv[26:0], rv[15:0]);
    chk("grant", 1'b0, walk_grant);
    op(OP_GSTAGE_INV, PRIV_SUP, 1'b0, rv[26:0], 16'h9);
    op(OP_WALK_FENCE, PRIV_SUP, 1'b0, 27'h0, 16'h0);
    chk("grant", 1'b1, walk_grant);
    for (int i = 0; i < 3; i++) look(ent[i], i == 1);
    $display("test cache done");
    for (int s = 0; s < 2; s++) begin
      axi(1, OFS_CTRL, s ? 32'h10 : 32'h0);
      slow <= 1'b1;
      push <= 1'b1;
      @(posedge clock);
      push <= 1'b0;
      op(OP_STORE_FENCE, PRIV_SUP, 1'b0, 27'h0, 16'h0);
      chk("drained", s == 0, stores_drained);
    end
    $display("test fences done");
    for (int i = 0; i < 8; i++) begin
      axi(1, OFS_CTRL, {i[2:1], 2'b00});
      ad_vs_stage <= i[0];
      ad_req <= 1'b1;
      @(posedge clock);
      ad_req <= 1'b0;
      @(posedge clock);
      chk("ad_update", i[0] ? i[2] : i[1], ad_update);
      chk("ad_fault", i[0] ? !i[2] : !i[1], ad_fault);
    end
    $display("test access dirty done");
    end_sim;
  end
endmodule // fgti_unit_tb
`default_nettype wire
